// *** qdcd_chan.sv ***
`timescale 1ns/1ps
`include "qdcd_params.svh"

// ----------------------------------------
// one channel: input buffer and converter register
// ----------------------------------------
module qdcd_chan (
  input wire logic clock,
  input wire logic rst,
  input wire logic wr,
  input wire logic ld,
  input wire logic pd_flag,
  input wire qdcd_pkg::qdcd_pd_t pd_sel,
  input wire qdcd_pkg::qdcd_code_t code_in,
  output qdcd_pkg::qdcd_code_t buf_code,
  output qdcd_pkg::qdcd_pd_t buf_pd,
  output qdcd_pkg::qdcd_code_t act_code,
  output qdcd_pkg::qdcd_pd_t act_pd
);
  import qdcd_pkg::*;

  qdcd_code_t buf_code_reg, buf_code_next;
  qdcd_pd_t buf_pd_reg, buf_pd_next;
  qdcd_code_t act_code_reg, act_code_next;
  qdcd_pd_t act_pd_reg, act_pd_next;

  // a power-down word changes only the mode, the code stays put
  always_comb begin
    buf_code_next = buf_code_reg;
    buf_pd_next = buf_pd_reg;
    if (wr) begin
      if (pd_flag) begin
        buf_pd_next = pd_sel; // [RULE19]
      end else begin
        buf_code_next = code_in; // [RULE18]
        buf_pd_next = `QDCD_PD_NORMAL;
      end
    end
    // transfer sees a write of the same frame
    act_code_next = ld ? buf_code_next : act_code_reg;
    act_pd_next = ld ? buf_pd_next : act_pd_reg;
  end

  // zero-scale and powered up after reset
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      buf_code_reg <= `QDCD_CODE_RST;
      buf_pd_reg <= `QDCD_PD_NORMAL;
      act_code_reg <= `QDCD_CODE_RST;
      act_pd_reg <= `QDCD_PD_NORMAL;
    end else begin
      buf_code_reg <= buf_code_next;
      buf_pd_reg <= buf_pd_next;
      act_code_reg <= act_code_next;
      act_pd_reg <= act_pd_next;
    end
  end

  assign buf_code = buf_code_reg;
  assign buf_pd = buf_pd_reg;
  assign act_code = act_code_reg;
  assign act_pd = act_pd_reg;
endmodule

// *** qdcd_host_model.sv ***
`timescale 1ns/1ps

// ----------------------------------------
// host serial port model
// ----------------------------------------
module qdcd_host_model (
  input wire logic clock,
  output logic frame_n,
  output logic sclk,
  output logic sdin
);
  // link idles with the strobe high and the serial clock parked high
  initial begin
    frame_n = 1'b1;
    sclk = 1'b1;
    sdin = 1'b0;
  end

  // shift nbits of w, msb first; a short count aborts the frame
  task automatic send(input logic [23:0] w, input int nbits);
    @(posedge clock);
    frame_n <= 1'b0;
    for (int i = 23; i > 23 - nbits; i--) begin
      sdin <= w[i];
      repeat (4) @(posedge clock);
      sclk <= 1'b0; // device takes the bit on this fall
      repeat (4) @(posedge clock);
      sclk <= 1'b1;
    end
    repeat (4) @(posedge clock);
    frame_n <= 1'b1;
    sdin <= ~sdin; // released line must not look like a held bit
    repeat (4) @(posedge clock);
  endtask
endmodule

// *** qdcd_params.svh ***
`ifndef QDCD_PARAMS_SVH
`define QDCD_PARAMS_SVH

// ----------------------------------------
// frame geometry
// ----------------------------------------
`define QDCD_NUM_CH 4
`define QDCD_WORD_W 24
`define QDCD_LAST_BIT 5'd23
`define QDCD_BIT_ADDR_HI 23
`define QDCD_BIT_ADDR_LO 22
`define QDCD_BIT_LD_HI 21
`define QDCD_BIT_LD_LO 20
`define QDCD_BIT_SEL_HI 18
`define QDCD_BIT_SEL_LO 17
`define QDCD_BIT_PD_FLAG 16
`define QDCD_BIT_PDM_HI 15
`define QDCD_BIT_PDM_LO 14
`define QDCD_BIT_REF_HI 13
`define QDCD_BIT_REF_LO 12
`define QDCD_BIT_DATA_HI 15
`define QDCD_BIT_DATA_LO 0

// ----------------------------------------
// field encodings
// ----------------------------------------
`define QDCD_LD_NONE 2'b00
`define QDCD_LD_ONE 2'b01
`define QDCD_LD_ALL 2'b10
`define QDCD_LD_BCAST 2'b11
`define QDCD_SEL_NONE 2'b00
`define QDCD_SEL_BCAST 2'b10
`define QDCD_PD_NORMAL 2'b00
`define QDCD_PD_1K 2'b01
`define QDCD_PD_100K 2'b10
`define QDCD_PD_HIZ 2'b11
`define QDCD_REF_DEFAULT 2'b00
`define QDCD_REF_ON 2'b01
`define QDCD_REF_OFF 2'b10

// ----------------------------------------
// register word indices and reset values
// ----------------------------------------
`define QDCD_REG_CTRL 4'h0
`define QDCD_REG_STATUS 4'h1
`define QDCD_REG_PD 4'h2
`define QDCD_REG_WORD 4'h3
`define QDCD_REG_CODE_BASE 2'b01
`define QDCD_CTRL_EN_RST 1'b1
`define QDCD_CTRL_ADDR_RST 2'b00
`define QDCD_CODE_RST 16'h0000
`define QDCD_COUNT_RST 8'h00

`endif

// *** qdcd_pkg.sv ***
package qdcd_pkg;
  typedef logic [15:0] qdcd_code_t;
  typedef logic [1:0] qdcd_pd_t;
  typedef enum logic [2:0] {
    QDCD_LINK_IDLE = 3'b001,
    QDCD_LINK_SHIFT = 3'b010,
    QDCD_LINK_HOLD = 3'b100
  } qdcd_link_t;
  typedef enum logic [2:0] {
    QDCD_REFM_DEFAULT = 3'b001,
    QDCD_REFM_ON = 3'b010,
    QDCD_REFM_OFF = 3'b100
  } qdcd_refm_t;
endpackage

// *** qdcd_sync.sv ***
`timescale 1ns/1ps

// ----------------------------------------
// two-stage synchroniser for one pin
// ----------------------------------------
module qdcd_sync #(
  parameter logic RST_VAL = 1'b0
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic d,
  output logic q
);
  logic meta_reg;
  logic q_reg;

  // first stage feeds only the second stage
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      meta_reg <= RST_VAL;
      q_reg <= RST_VAL;
    end else begin
      meta_reg <= d;
      q_reg <= meta_reg;
    end
  end

  assign q = q_reg;
endmodule

// *** qdcd_top.sv ***
`timescale 1ns/1ps
`include "qdcd_params.svh"

// How it works
// RULE1: select bits 18:17 pick buffer A, B, C or D for 00..11.
// RULE2: power-down flag with mode 01 parks the channel on 1k to ground.
// RULE3: power-down flag with mode 10 parks the channel on 100k to ground.
// RULE4: power-down flag with mode 11 leaves the channel output high-impedance.
// RULE5: load 10 writes the buffer then transfers all four together.
// RULE6: load 01 writes and transfers only the selected channel at frame end.
// RULE7: load 00 writes the buffer only; outputs wait for a later transfer.
// RULE8: load 11 with select 10 writes all buffers and updates all channels.
// RULE9: such a broadcast with high-impedance mode powers down all four at once.
// RULE10: reference word with 0001 forces the internal reference on.
// RULE11: reference word with 0010 forces the internal reference off.
// RULE12: reference word 0000 or reset restores default reference mode.
// RULE13: in default mode the reference drops once all channels power down.
// RULE14: in default mode the reference returns when any channel runs again.
// RULE15: updates take effect after the 24th falling serial clock edge.
// RULE16: single-channel loads change each channel on its own frame only.
// RULE17: host puts the strapped address level in bits 23 and 22.
// RULE18: power-down flag 0 means normal running on the 16-bit code.
// RULE19: entering power-down keeps the stored converter code.
// RULE20: host sends the word most significant bit first.
// RULE21: frame strobe low for 24 clocks; bits taken on falling edges.
module qdcd_top #(
  parameter int NUM_CH = 4
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic frame_n,
  input wire logic sclk,
  input wire logic sdin,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output qdcd_pkg::qdcd_code_t [NUM_CH-1:0] dac_code,
  output qdcd_pkg::qdcd_pd_t [NUM_CH-1:0] pd_mode,
  output logic ref_on,
  output logic dac_update
);
  import qdcd_pkg::*;

  if (NUM_CH != `QDCD_NUM_CH) begin : g_bad_ch
    $error("qdcd_top: the select field serves exactly four channels");
  end

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic frame_s;
  logic sclk_s;
  logic sdin_s;

  qdcd_sync #(.RST_VAL(1'b1)) u_sync_frame (
    .clock(clock), .rst(rst), .d(frame_n), .q(frame_s));
  qdcd_sync #(.RST_VAL(1'b0)) u_sync_sclk (
    .clock(clock), .rst(rst), .d(sclk), .q(sclk_s));
  qdcd_sync #(.RST_VAL(1'b0)) u_sync_sdin (
    .clock(clock), .rst(rst), .d(sdin), .q(sdin_s));

  // ----------------------------------------
  // serial frame receiver
  // ----------------------------------------
  qdcd_link_t st_reg, st_next;
  logic [4:0] cnt_reg, cnt_next;
  logic [`QDCD_WORD_W-1:0] sh_reg, sh_next;
  logic [`QDCD_WORD_W-1:0] word_reg, word_next;
  logic cmd_valid_reg, cmd_valid_next;
  logic sclk_d_reg, sclk_d_next;
  logic miss_reg, miss_next;
  logic en_reg, en_next;
  logic [1:0] dev_addr_reg, dev_addr_next;
  logic sclk_fall;
  logic [`QDCD_WORD_W-1:0] new_word;

  // sdin is aligned with sclk since both pass the same two stages
  assign sclk_fall = sclk_d_reg & ~sclk_s;
  assign new_word = {sh_reg[`QDCD_WORD_W-2:0], sdin_s}; // [RULE20]

  // frame ends early: word dropped; bits past the 24th are ignored
  always_comb begin
    st_next = st_reg;
    cnt_next = cnt_reg;
    sh_next = sh_reg;
    word_next = word_reg;
    cmd_valid_next = 1'b0;
    miss_next = miss_reg;
    sclk_d_next = sclk_s;
    unique case (st_reg)
      QDCD_LINK_IDLE: begin
        if (!frame_s) begin
          st_next = QDCD_LINK_SHIFT;
          cnt_next = 5'd0;
        end
      end
      QDCD_LINK_SHIFT: begin
        if (frame_s) begin
          st_next = QDCD_LINK_IDLE;
        end else if (sclk_fall) begin
          sh_next = new_word; // [RULE21]
          cnt_next = cnt_reg + 5'd1;
          if (cnt_reg == `QDCD_LAST_BIT) begin
            st_next = QDCD_LINK_HOLD; // [RULE15]
            word_next = new_word;
            // word is acted on only when its address bits match the strap
            if (en_reg &&
                new_word[`QDCD_BIT_ADDR_HI:`QDCD_BIT_ADDR_LO] == dev_addr_reg) begin
              cmd_valid_next = 1'b1; // [RULE17]
              miss_next = 1'b0;
            end else begin
              miss_next = 1'b1;
            end
          end
        end
      end
      QDCD_LINK_HOLD: begin
        if (frame_s) begin
          st_next = QDCD_LINK_IDLE;
        end
      end
      default: begin
        st_next = QDCD_LINK_IDLE;
      end
    endcase
  end

  // receiver registers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_reg <= QDCD_LINK_IDLE;
      cnt_reg <= 5'd0;
      sh_reg <= 24'h00_0000;
      word_reg <= 24'h00_0000;
      cmd_valid_reg <= 1'b0;
      miss_reg <= 1'b0;
      sclk_d_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      sh_reg <= sh_next;
      word_reg <= word_next;
      cmd_valid_reg <= cmd_valid_next;
      miss_reg <= miss_next;
      sclk_d_reg <= sclk_d_next;
    end
  end

  // ----------------------------------------
  // command decode
  // ----------------------------------------
  logic [1:0] ld_w;
  logic [1:0] sel_w;
  logic pdf_w;
  logic [1:0] pdm_w;
  logic [1:0] refsel_w;
  qdcd_code_t data_w;
  qdcd_pd_t new_pd;
  logic is_ref;
  logic is_bcast;
  logic [NUM_CH-1:0] wr_en;
  logic [NUM_CH-1:0] ld_en;

  assign ld_w = word_reg[`QDCD_BIT_LD_HI:`QDCD_BIT_LD_LO];
  assign sel_w = word_reg[`QDCD_BIT_SEL_HI:`QDCD_BIT_SEL_LO];
  assign pdf_w = word_reg[`QDCD_BIT_PD_FLAG];
  assign pdm_w = word_reg[`QDCD_BIT_PDM_HI:`QDCD_BIT_PDM_LO];
  assign refsel_w = word_reg[`QDCD_BIT_REF_HI:`QDCD_BIT_REF_LO];
  assign data_w = word_reg[`QDCD_BIT_DATA_HI:`QDCD_BIT_DATA_LO];
  assign new_pd = pdf_w ? pdm_w : `QDCD_PD_NORMAL; // [RULE2] [RULE3] [RULE4]
  assign is_ref = pdf_w && ld_w == `QDCD_LD_NONE && sel_w == `QDCD_SEL_NONE &&
                  pdm_w == `QDCD_PD_NORMAL;
  assign is_bcast = ld_w == `QDCD_LD_BCAST && sel_w == `QDCD_SEL_BCAST; // [RULE8]

  // load 11 with another select is not a known command and is dropped
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      wr_en[i] = cmd_valid_reg && !is_ref &&
                 (is_bcast || (ld_w != `QDCD_LD_BCAST && sel_w == 2'(i))); // [RULE1]
      ld_en[i] = cmd_valid_reg &&
                 (is_bcast || ld_w == `QDCD_LD_ALL || // [RULE5] [RULE9]
                  (ld_w == `QDCD_LD_ONE && sel_w == 2'(i))); // [RULE6] [RULE16]
    end
  end

  // ----------------------------------------
  // channels
  // ----------------------------------------
  qdcd_code_t [NUM_CH-1:0] buf_code;
  qdcd_pd_t [NUM_CH-1:0] buf_pd;

  for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
    qdcd_chan u_chan (
      .clock(clock),
      .rst(rst),
      .wr(wr_en[g]),
      .ld(ld_en[g]), // [RULE7]
      .pd_flag(pdf_w),
      .pd_sel(new_pd),
      .code_in(data_w),
      .buf_code(buf_code[g]),
      .buf_pd(buf_pd[g]),
      .act_code(dac_code[g]),
      .act_pd(pd_mode[g])
    );
  end

  // ----------------------------------------
  // reference control
  // ----------------------------------------
  qdcd_refm_t refm_reg, refm_next;
  logic ref_on_reg, ref_on_next;
  logic update_reg, update_next;
  logic [7:0] frames_reg, frames_next;
  logic all_down;

  // in default mode the reference follows channel state one cycle after the outputs move
  always_comb begin
    all_down = 1'b1;
    for (int i = 0; i < NUM_CH; i++) begin
      all_down = all_down && pd_mode[i] != `QDCD_PD_NORMAL;
    end
    refm_next = refm_reg;
    if (cmd_valid_reg && is_ref) begin
      unique case (refsel_w)
        `QDCD_REF_DEFAULT: refm_next = QDCD_REFM_DEFAULT; // [RULE12]
        `QDCD_REF_ON: refm_next = QDCD_REFM_ON; // [RULE10]
        `QDCD_REF_OFF: refm_next = QDCD_REFM_OFF; // [RULE11]
        default: refm_next = refm_reg;
      endcase
    end
    unique case (refm_reg)
      QDCD_REFM_ON: ref_on_next = 1'b1;
      QDCD_REFM_OFF: ref_on_next = 1'b0;
      QDCD_REFM_DEFAULT: ref_on_next = !all_down; // [RULE13] [RULE14]
      default: ref_on_next = 1'b1;
    endcase
    update_next = |ld_en;
    frames_next = cmd_valid_reg ? frames_reg + 8'd1 : frames_reg;
  end

  // reset brings the default reference mode back
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      refm_reg <= QDCD_REFM_DEFAULT; // [RULE12]
      ref_on_reg <= 1'b1;
      update_reg <= 1'b0;
      frames_reg <= `QDCD_COUNT_RST;
    end else begin
      refm_reg <= refm_next;
      ref_on_reg <= ref_on_next;
      update_reg <= update_next;
      frames_reg <= frames_next;
    end
  end

  assign ref_on = ref_on_reg;
  assign dac_update = update_reg;

  // ----------------------------------------
  // avalon-mm slave
  // ----------------------------------------
  logic wait_reg, wait_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [31:0] rmux;
  logic [1:0] refm_code;

  always_comb begin
    unique case (refm_reg)
      QDCD_REFM_ON: refm_code = `QDCD_REF_ON;
      QDCD_REFM_OFF: refm_code = `QDCD_REF_OFF;
      default: refm_code = `QDCD_REF_DEFAULT;
    endcase
    rmux = 32'h0000_0000;
    if (avs_address == `QDCD_REG_CTRL) begin
      rmux = {29'h0000_0000, dev_addr_reg, en_reg};
    end else if (avs_address == `QDCD_REG_STATUS) begin
      rmux = {16'h0000, frames_reg, 4'h0, miss_reg, ref_on_reg, refm_code};
    end else if (avs_address == `QDCD_REG_PD) begin
      rmux = {24'h00_0000, pd_mode};
    end else if (avs_address == `QDCD_REG_WORD) begin
      rmux = {8'h00, word_reg};
    end else if (avs_address[3:2] == `QDCD_REG_CODE_BASE) begin
      rmux = {16'h0000, dac_code[avs_address[1:0]]};
    end
  end

  // one wait cycle per access; writes land on the edge that ends it
  always_comb begin
    wait_next = 1'b1;
    rdata_next = rdata_reg;
    en_next = en_reg;
    dev_addr_next = dev_addr_reg;
    if ((avs_read || avs_write) && wait_reg) begin
      wait_next = 1'b0;
      if (avs_read) begin
        rdata_next = rmux;
      end
    end
    if (avs_write && !wait_reg && avs_address == `QDCD_REG_CTRL &&
        avs_byteenable[0]) begin
      en_next = avs_writedata[0];
      dev_addr_next = avs_writedata[2:1];
    end
  end

  // bus registers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wait_reg <= 1'b1;
      rdata_reg <= 32'h0000_0000;
      en_reg <= `QDCD_CTRL_EN_RST;
      dev_addr_reg <= `QDCD_CTRL_ADDR_RST;
    end else begin
      wait_reg <= wait_next;
      rdata_reg <= rdata_next;
      en_reg <= en_next;
      dev_addr_reg <= dev_addr_next;
    end
  end

  assign avs_waitrequest = wait_reg;
  assign avs_readdata = rdata_reg;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  a_sel_route: assert property ( // [RULE1] [RULE6] [RULE18]
    cmd_valid_reg && ld_w == `QDCD_LD_ONE && !pdf_w |=>
      dac_code[$past(sel_w)] == $past(data_w) && pd_mode[$past(sel_w)] == `QDCD_PD_NORMAL)
    else $error("single load did not reach the selected channel");
  a_pd_1k: assert property ( // [RULE2] [RULE19]
    cmd_valid_reg && ld_w == `QDCD_LD_ONE && pdf_w && pdm_w == `QDCD_PD_1K |=>
      pd_mode[$past(sel_w)] == `QDCD_PD_1K && $stable(buf_code) &&
      dac_code[$past(sel_w)] == buf_code[$past(sel_w)])
    else $error("1k power-down not applied or code disturbed");
  a_pd_100k: assert property ( // [RULE3]
    cmd_valid_reg && ld_w == `QDCD_LD_ONE && pdf_w && pdm_w == `QDCD_PD_100K |=>
      pd_mode[$past(sel_w)] == `QDCD_PD_100K)
    else $error("100k power-down not applied");
  a_pd_hiz: assert property ( // [RULE4]
    cmd_valid_reg && ld_w == `QDCD_LD_ONE && pdf_w && pdm_w == `QDCD_PD_HIZ |=>
      pd_mode[$past(sel_w)] == `QDCD_PD_HIZ)
    else $error("high-impedance power-down not applied");
  a_load_all: assert property ( // [RULE5]
    cmd_valid_reg && ld_w == `QDCD_LD_ALL |=> dac_code == buf_code && pd_mode == buf_pd)
    else $error("simultaneous transfer incomplete");
  a_hold_only: assert property ( // [RULE7]
    cmd_valid_reg && ld_w == `QDCD_LD_NONE |=> $stable(dac_code) && $stable(pd_mode))
    else $error("buffer-only write moved an output");
  a_bcast_data: assert property ( // [RULE8]
    cmd_valid_reg && is_bcast && !pdf_w |=> dac_code == {NUM_CH{$past(data_w)}})
    else $error("broadcast data missing on a channel");
  a_bcast_hiz: assert property ( // [RULE9]
    cmd_valid_reg && is_bcast && pdf_w && pdm_w == `QDCD_PD_HIZ |=>
      pd_mode == {NUM_CH{`QDCD_PD_HIZ}})
    else $error("broadcast power-down incomplete");
  a_ref_force_on: assert property ( // [RULE10]
    cmd_valid_reg && is_ref && refsel_w == `QDCD_REF_ON |=> ##1 ref_on[*3])
    else $error("forced-on reference not on");
  a_ref_force_off: assert property ( // [RULE11]
    cmd_valid_reg && is_ref && refsel_w == `QDCD_REF_OFF |=> ##1 !ref_on[*3])
    else $error("forced-off reference still on");
  a_ref_default: assert property ( // [RULE12]
    cmd_valid_reg && is_ref && refsel_w == `QDCD_REF_DEFAULT |=> refm_reg == QDCD_REFM_DEFAULT)
    else $error("default reference mode not restored");
  a_ref_auto_off: assert property ( // [RULE13]
    refm_reg == QDCD_REFM_DEFAULT && refm_next == QDCD_REFM_DEFAULT && all_down |=> !ref_on)
    else $error("reference stayed on with all channels down");
  a_ref_auto_on: assert property ( // [RULE14]
    refm_reg == QDCD_REFM_DEFAULT && refm_next == QDCD_REFM_DEFAULT && !all_down |=> ref_on)
    else $error("reference off while a channel runs");
  a_frame_end: assert property ( // [RULE15] [RULE21]
    $rose(dac_update) |-> $past(st_reg, 2) == QDCD_LINK_SHIFT && $past(sclk_fall, 2) &&
      $past(cnt_reg, 2) == `QDCD_LAST_BIT)
    else $error("update not tied to the last falling edge");
  a_seq_indep: assert property ( // [RULE16]
    cmd_valid_reg && ld_w == `QDCD_LD_ONE && sel_w != 2'd0 |=>
      $stable(dac_code[0]) && $stable(pd_mode[0]))
    else $error("single load disturbed another channel");

  c_bcast: cover property (cmd_valid_reg && is_bcast);
  c_ref_off: cover property (refm_reg == QDCD_REFM_OFF ##1 cmd_valid_reg);
  c_auto_off: cover property (refm_reg == QDCD_REFM_DEFAULT && all_down ##1 !ref_on);
  c_load_all: cover property (cmd_valid_reg && ld_w == `QDCD_LD_ALL);
endmodule

// *** test_quad_dac_command_decoder.sv ***
`timescale 1ns/1ps

module test_quad_dac_command_decoder;
  import qdcd_pkg::*;
  logic clock, rst, frame_n, sclk, sdin;
  logic [3:0] avs_address, avs_byteenable;
  logic avs_read, avs_write, avs_waitrequest, ref_on, dac_update, er;
  logic [31:0] avs_writedata, avs_readdata, q;
  qdcd_code_t [3:0] dac_code;
  qdcd_pd_t [3:0] pd_mode;
  qdcd_code_t ec [4];
  qdcd_pd_t ep [4];
  int mismatches, n_compared, n_upd, cyc;

  qdcd_top #(.NUM_CH(4)) i_qdcd_top (.clock, .rst, .frame_n, .sclk, .sdin, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
    .dac_code, .pd_mode, .ref_on, .dac_update);
  qdcd_host_model i_qdcd_host_model (.clock, .frame_n, .sclk, .sdin);

  // ----------------------------------------
  // clock, update counter, hang guard
  // ----------------------------------------
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  // a frame lasts about 210 cycles; 30000 leaves wide slack
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (dac_update === 1'b1) n_upd <= n_upd + 1;
    if (cyc == 30000) begin
      mismatches++;
      give_verdict();
    end
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic give_verdict();
    $display("compared %0d, mismatched %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  // expected model against every output of every channel
  task automatic cmp_all();
    for (int i = 0; i < 4; i++) begin
      chk("dac_code", {16'h0, ec[i]}, {16'h0, dac_code[i]});
      chk("pd_mode", {30'h0, ep[i]}, {30'h0, pd_mode[i]});
    end
    chk("ref_on", {31'h0, er}, {31'h0, ref_on});
  endtask

  // strapped address pins are both low in this bench, except while t_refused sets them to 01
  function automatic logic [23:0] mk(input logic [1:0] ld, input logic [1:0] sel,
      input logic pd, input logic [15:0] d);
    return {2'b00, ld, 1'b0, sel, pd, d};
  endfunction

  // send a frame, let it land, then count transfer pulses
  task automatic frame(input logic [23:0] w, input int nbits, input int upd);
    int n0;
    n0 = n_upd;
    i_qdcd_host_model.send(w, nbits);
    repeat (6) @(posedge clock);
    chk("updates", upd, n_upd - n0);
  endtask

  // one avalon access; held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    @(posedge clock);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    for (n = 0; n < 50; n++) begin
      @(posedge clock);
      if (avs_waitrequest === 1'b0) break;
    end
    if (n == 50) chk("waitrequest", 0, 1);
    // data taken at the same edge that sees waitrequest low
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    bus(1'b0, 4'h1, 32'h0);
    chk("status", 32'h4, q);
    cmp_all();
    $display("done reset");
  endtask

  task automatic t_buffered();
    for (int i = 0; i < 3; i++) begin
      frame(mk(2'b00, 2'(i), 1'b0, 16'(16'h1111 * (i + 1))), 24, 0);
      cmp_all();
    end
    frame(mk(2'b10, 2'b11, 1'b0, 16'h4444), 24, 1);
    for (int i = 0; i < 4; i++) ec[i] = 16'(16'h1111 * (i + 1));
    cmp_all();
    $display("done buffered");
  endtask

  task automatic t_single();
    for (int i = 0; i < 4; i++) begin
      ec[i] = 16'h5a00 + 16'(i);
      frame(mk(2'b01, 2'(i), 1'b0, ec[i]), 24, 1);
      cmp_all();
    end
    $display("done single");
  endtask

  task automatic t_powerdown();
    for (int i = 0; i < 3; i++) begin
      ep[i] = 2'(i + 1);
      frame(mk(2'b01, 2'(i), 1'b1, {ep[i], 14'h0}), 24, 1);
      cmp_all();
    end
    frame(mk(2'b11, 2'b10, 1'b1, 16'hc000), 24, 1);
    for (int i = 0; i < 4; i++) ep[i] = 2'b11;
    er = 1'b0;
    cmp_all();
    frame(mk(2'b01, 2'b00, 1'b0, 16'h1234), 24, 1);
    ec[0] = 16'h1234;
    ep[0] = 2'b00;
    er = 1'b1;
    cmp_all();
    $display("done powerdown");
  endtask

  task automatic t_refmodes();
    frame(mk(2'b00, 2'b00, 1'b1, 16'h1000), 24, 0);
    frame(mk(2'b11, 2'b10, 1'b1, 16'hc000), 24, 1);
    for (int i = 0; i < 4; i++) ep[i] = 2'b11;
    cmp_all();
    frame(mk(2'b00, 2'b00, 1'b1, 16'h2000), 24, 0);
    frame(mk(2'b11, 2'b10, 1'b0, 16'habcd), 24, 1);
    for (int i = 0; i < 4; i++) begin
      ec[i] = 16'habcd;
      ep[i] = 2'b00;
    end
    er = 1'b0;
    cmp_all();
    frame(mk(2'b00, 2'b00, 1'b1, 16'h0000), 24, 0);
    er = 1'b1;
    cmp_all();
    $display("done refmodes");
  endtask

  task automatic t_refused();
    frame(mk(2'b01, 2'b01, 1'b0, 16'h7777), 12, 0);
    cmp_all();
    bus(1'b1, 4'h0, 32'h3);
    frame(mk(2'b01, 2'b01, 1'b0, 16'h7777), 24, 0);
    cmp_all();
    bus(1'b0, 4'h1, 32'h0);
    chk("miss", 32'h1, {31'h0, q[3]});
    bus(1'b1, 4'h0, 32'h1);
    frame(mk(2'b11, 2'b01, 1'b0, 16'h9999), 24, 0);
    cmp_all();
    bus(1'b0, 4'h5, 32'h0);
    chk("code_b", {16'h0, ec[1]}, q);
    bus(1'b0, 4'h8, 32'h0);
    chk("unmapped", 32'h0, q);
    $display("done refused");
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    rst = 1'b1;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    mismatches = 0;
    n_compared = 0;
    n_upd = 0;
    cyc = 0;
    er = 1'b1;
    for (int i = 0; i < 4; i++) begin
      ec[i] = 16'h0000;
      ep[i] = 2'b00;
    end
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    repeat (3) @(posedge clock);
    t_reset();
    t_buffered();
    t_single();
    t_powerdown();
    t_refmodes();
    t_refused();
    give_verdict();
  end
endmodule
